// ===== cei_pkg.sv
// Constants and types for the clock generator event interrupt block
package cei_pkg;
  // ==========================================================
  // Register indices, byte address is four times the index
  localparam logic [5:0] IDX_LIVE     = 6'h0D;
  localparam logic [5:0] IDX_MASK     = 6'h0E;
  localparam logic [5:0] IDX_POL      = 6'h0F;
  localparam logic [5:0] IDX_FLAG     = 6'h10;
  localparam logic [5:0] IDX_CTRL     = 6'h11;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h18;
  localparam logic [5:0] IDX_IRQ_EN   = 6'h19;
  // ==========================================================
  // Field positions
  localparam int BIT_UNLOCK  = 7;
  localparam int BIT_MISSING = 6;
  localparam int BIT_TUNING  = 5;
  localparam int BIT_SWITCH  = 1;
  localparam int BIT_INT_EN  = 0;
  localparam int BIT_AND_OR  = 1;
  localparam logic [7:0] SRC_VALID = 8'hE2;
  localparam logic [7:0] CTRL_VALID = 8'h03;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  // ==========================================================
  // Types
  typedef struct packed {
    logic pll_unlock;
    logic input_missing;
    logic vco_tuning;
    logic backup_to_main_switch;
  } cei_src_t;
  typedef struct packed {
    logic and_mode;
    logic int_en;
  } cei_ctrl_t;
endpackage

// ===== cei_event_irq.sv
// Event interrupt logic with Avalon-MM register slave
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
module cei_event_irq #(
  parameter int ADDR_W = 8
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  input  wire logic              i_pll_unlock,
  input  wire logic              i_input_missing,
  input  wire logic              i_vco_tuning,
  input  wire logic              i_backup_to_main_switch,
  input  wire logic [ADDR_W-1:0] i_address,
  input  wire logic              i_read,
  input  wire logic              i_write,
  input  wire logic [31:0]       i_writedata,
  input  wire logic [3:0]        i_byteenable,
  output logic      [31:0]       o_readdata,
  output logic                   o_waitrequest,
  output logic                   o_status_int,
  output logic                   o_irq
);
  // ==========================================================
  // Declarations
  cei_pkg::cei_src_t  src_meta_reg;
  cei_pkg::cei_src_t  src_sync_reg;
  cei_pkg::cei_ctrl_t ctrl_reg;
  logic [7:0] live_reg;
  logic [7:0] live_prev_reg;
  logic [7:0] mask_reg;
  logic [7:0] pol_reg;
  logic [7:0] flag_reg;
  logic [7:0] flag_next;
  logic [7:0] irq_stat_reg;
  logic [7:0] irq_stat_next;
  logic [7:0] irq_en_reg;
  logic [7:0] live_next;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] flag_set;
  logic [7:0] active;
  logic       int_next;
  logic       wr_go;
  logic       rd_go;
  logic       byte0;
  logic [5:0] idx;
  logic [7:0] rd_byte;

  function automatic logic [5:0] addr_index(input logic [ADDR_W-1:0] a);
    return a[7:2];
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] i);
    return (a[1:0] == 2'h0) && (addr_index(a) == i);
  endfunction

  // ==========================================================
  // Source synchronisers
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      src_meta_reg <= '0;
      src_sync_reg <= '0;
    end else begin
      src_meta_reg <= {i_pll_unlock, i_input_missing, i_vco_tuning, i_backup_to_main_switch};
      src_sync_reg <= src_meta_reg;
    end
  end

  // ==========================================================
  // Live status
  always_comb begin
    live_next = cei_pkg::RST_BYTE;
    live_next[cei_pkg::BIT_UNLOCK] = src_sync_reg.pll_unlock & ~src_sync_reg.input_missing;
    live_next[cei_pkg::BIT_MISSING] = src_sync_reg.input_missing;
    live_next[cei_pkg::BIT_TUNING] = src_sync_reg.vco_tuning;
    live_next[cei_pkg::BIT_SWITCH] = src_sync_reg.backup_to_main_switch;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      live_reg      <= cei_pkg::RST_BYTE;
      live_prev_reg <= cei_pkg::RST_BYTE;
    end else begin
      live_reg      <= live_next;
      live_prev_reg <= live_reg;
    end
  end

  // ==========================================================
  // Bus handshake
  assign byte0 = i_byteenable[0];
  assign idx   = addr_index(i_address);
  assign wr_go = i_write && !o_waitrequest && byte0;
  assign rd_go = i_read && o_waitrequest;

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_waitrequest <= 1'b1;
    end else if ((i_read || i_write) && o_waitrequest) begin
      o_waitrequest <= 1'b0;
    end else begin
      o_waitrequest <= 1'b1;
    end
  end

  always_comb begin
    rd_byte = cei_pkg::RST_BYTE;
    if (i_address[1:0] == 2'h0) begin
      case (idx)
        cei_pkg::IDX_LIVE:     rd_byte = live_reg;
        cei_pkg::IDX_MASK:     rd_byte = mask_reg;
        cei_pkg::IDX_POL:      rd_byte = pol_reg;
        cei_pkg::IDX_FLAG:     rd_byte = flag_reg;
        cei_pkg::IDX_CTRL:     rd_byte = {6'h00, ctrl_reg};
        cei_pkg::IDX_IRQ_STAT: rd_byte = irq_stat_reg;
        cei_pkg::IDX_IRQ_EN:   rd_byte = irq_en_reg;
        default:               rd_byte = cei_pkg::RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_readdata <= 32'h0000_0000;
    end else if (rd_go) begin
      o_readdata <= {24'h00_0000, rd_byte};
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      mask_reg   <= cei_pkg::RST_BYTE;
      pol_reg    <= cei_pkg::RST_BYTE;
      ctrl_reg   <= '0;
      irq_en_reg <= cei_pkg::RST_BYTE;
    end else if (wr_go) begin
      if (hit(i_address, cei_pkg::IDX_MASK)) begin
        mask_reg <= i_writedata[7:0];
      end
      if (hit(i_address, cei_pkg::IDX_POL)) begin
        pol_reg <= i_writedata[7:0];
      end
      if (hit(i_address, cei_pkg::IDX_CTRL)) begin
        ctrl_reg <= i_writedata[1:0];
      end
      if (hit(i_address, cei_pkg::IDX_IRQ_EN)) begin
        irq_en_reg <= i_writedata[7:0] & cei_pkg::SRC_VALID;
      end
    end
  end

  // ==========================================================
  // Edge detection and latched flags
  assign rise = live_reg & ~live_prev_reg;
  assign fall = ~live_reg & live_prev_reg;
  assign flag_set = ctrl_reg.int_en ? (((pol_reg & rise) | (~pol_reg & fall)) & cei_pkg::SRC_VALID)
                                    : cei_pkg::RST_BYTE;

  always_comb begin
    flag_next = flag_reg;
    if (wr_go && hit(i_address, cei_pkg::IDX_FLAG)) begin
      flag_next = flag_reg & i_writedata[7:0];
    end
    flag_next = flag_next | flag_set;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      flag_reg <= cei_pkg::RST_BYTE;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // ==========================================================
  // Combined interrupt on the status pin
  assign active = flag_reg & ~mask_reg & cei_pkg::SRC_VALID;

  always_comb begin
    if (!ctrl_reg.int_en) begin
      int_next = 1'b0;
    end else if (ctrl_reg.and_mode) begin
      int_next = (active != 8'h00) && (active == (~mask_reg & cei_pkg::SRC_VALID));
    end else begin
      int_next = (active != 8'h00);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_status_int <= 1'b0;
    end else begin
      o_status_int <= int_next;
    end
  end

  // ==========================================================
  // System interrupt, sticky status with write-one-to-clear
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (wr_go && hit(i_address, cei_pkg::IDX_IRQ_STAT)) begin
      irq_stat_next = irq_stat_reg & ~i_writedata[7:0];
    end
    irq_stat_next = irq_stat_next | flag_set;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      irq_stat_reg <= cei_pkg::RST_BYTE;
      o_irq        <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      o_irq        <= |(irq_stat_next & irq_en_reg);
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  logic wr_flag;
  assign wr_flag = wr_go && hit(i_address, cei_pkg::IDX_FLAG);

  a_live_tracks: assert property (
    ##1 live_reg[cei_pkg::BIT_TUNING] == $past(src_sync_reg.vco_tuning)
  ) else $error("live tuning bit does not follow source");

  a_unlock_prec: assert property (
    live_reg[cei_pkg::BIT_MISSING] |-> !live_reg[cei_pkg::BIT_UNLOCK]
  ) else $error("unlock shown while input missing");

  a_unlock_live: assert property (
    $past(src_sync_reg.pll_unlock) && !$past(src_sync_reg.input_missing) |-> live_reg[cei_pkg::BIT_UNLOCK]
  ) else $error("unlock not shown");

  a_switch_live: assert property (
    ##1 live_reg[cei_pkg::BIT_SWITCH] == $past(src_sync_reg.backup_to_main_switch)
  ) else $error("switch bit does not follow source");

  a_missing_live: assert property (
    ##1 live_reg[cei_pkg::BIT_MISSING] == $past(src_sync_reg.input_missing)
  ) else $error("missing bit does not follow source");

  a_rise_sets: assert property (
    ctrl_reg.int_en && pol_reg[cei_pkg::BIT_TUNING] && rise[cei_pkg::BIT_TUNING]
      |=> flag_reg[cei_pkg::BIT_TUNING]
  ) else $error("rising edge did not set flag");

  a_fall_sets: assert property (
    ctrl_reg.int_en && !pol_reg[cei_pkg::BIT_MISSING] && fall[cei_pkg::BIT_MISSING]
      |=> flag_reg[cei_pkg::BIT_MISSING]
  ) else $error("falling edge did not set flag");

  a_wrong_edge: assert property (
    !wr_flag && !flag_reg[cei_pkg::BIT_UNLOCK] && pol_reg[cei_pkg::BIT_UNLOCK] && !rise[cei_pkg::BIT_UNLOCK]
      |=> !flag_reg[cei_pkg::BIT_UNLOCK]
  ) else $error("flag set without selected edge");

  a_no_record_off: assert property (
    !ctrl_reg.int_en |=> (flag_reg & ~$past(flag_reg)) == 8'h00
  ) else $error("flag recorded while disabled");

  a_clear_zero: assert property (
    wr_flag && !i_writedata[cei_pkg::BIT_UNLOCK] && !flag_set[cei_pkg::BIT_UNLOCK]
      |=> !flag_reg[cei_pkg::BIT_UNLOCK]
  ) else $error("writing zero did not clear flag");

  a_write_one_keeps: assert property (
    wr_flag && i_writedata[cei_pkg::BIT_SWITCH] && flag_reg[cei_pkg::BIT_SWITCH]
      |=> flag_reg[cei_pkg::BIT_SWITCH]
  ) else $error("writing one changed flag");

  a_pin_quiet_off: assert property (
    !ctrl_reg.int_en |=> !o_status_int
  ) else $error("status pin active while disabled");

  a_or_combine: assert property (
    ctrl_reg.int_en && !ctrl_reg.and_mode && (active != 8'h00) |=> o_status_int
  ) else $error("or combine failed");

  a_and_combine: assert property (
    ctrl_reg.int_en && ctrl_reg.and_mode && ((~active & ~mask_reg & cei_pkg::SRC_VALID) != 8'h00)
      |=> !o_status_int
  ) else $error("and combine fired with a flag missing");

  a_mask_blocks: assert property (
    ((flag_reg & ~mask_reg & cei_pkg::SRC_VALID) == 8'h00) |=> !o_status_int
  ) else $error("masked flag raised interrupt");

  a_bus_answer: assert property (
    (i_read || i_write) && o_waitrequest |=> !o_waitrequest
  ) else $error("bus request not answered in one cycle");

  c_flag_set:   cover property (ctrl_reg.int_en ##1 (flag_reg != 8'h00));
  c_flag_clear: cover property (wr_flag && (flag_reg != 8'h00) ##1 (flag_reg == 8'h00));
  c_and_fire:   cover property (ctrl_reg.and_mode && o_status_int);
  c_or_fire:    cover property (ctrl_reg.int_en && !ctrl_reg.and_mode && o_status_int);
  c_irq_out:    cover property ($rose(o_irq));
endmodule

// ===== cei_host_model.sv
// Host processor model: Avalon-MM master for the event interrupt registers
`timescale 1ns/1ps
module cei_host_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_waitrequest,
  input  wire logic [31:0] i_readdata,
  output logic      [7:0]  o_address,
  output logic             o_read,
  output logic             o_write,
  output logic      [31:0] o_writedata,
  output logic      [3:0]  o_byteenable
);
  initial begin
    o_address    = 8'h00;
    o_read       = 1'b0;
    o_write      = 1'b0;
    o_writedata  = 32'h00000000;
    o_byteenable = 4'h0;
  end
  // ==========================================================
  // One transfer, held until waitrequest is sampled low
  task automatic xfer(input logic rd, input logic [5:0] idx, input logic [1:0] lo, input logic [3:0] ben,
                      input logic [7:0] wd, output logic [7:0] rdata);
    @(posedge i_clk_sys);
    o_address    <= {idx, lo};
    o_read       <= rd;
    o_write      <= ~rd;
    o_writedata  <= {24'h000000, wd};
    o_byteenable <= ben;
    do @(posedge i_clk_sys); while (i_waitrequest !== 1'b0);
    rdata = i_readdata[7:0];
    o_read  <= 1'b0;
    o_write <= 1'b0;
  endtask
endmodule

// ===== tb_top.sv
// Self-checking testbench for the event interrupt block
`timescale 1ns/1ps
module tb_top;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  cei_pkg::cei_src_t src = '0;
  logic [7:0]        addr;
  logic              rd;
  logic              wr;
  logic [31:0]       wdata;
  logic [3:0]        be;
  logic [31:0]       rdata;
  logic              wait_req;
  logic              stat_int;
  logic              irq;
  logic [7:0]        val;
  logic [7:0]        v;
  logic [1:0]        lo = 2'h0;
  logic [3:0]        ben = 4'h1;
  int                failures = 0;
  int                comparisons = 0;
  int                cycles = 0;
  always #10 clk = ~clk;
  cei_event_irq #(.ADDR_W(8)) i_cei_event_irq (
    .i_clk_sys(clk), .i_resetn(rst_n), .i_pll_unlock(src.pll_unlock), .i_input_missing(src.input_missing),
    .i_vco_tuning(src.vco_tuning), .i_backup_to_main_switch(src.backup_to_main_switch), .i_address(addr),
    .i_read(rd), .i_write(wr), .i_writedata(wdata), .i_byteenable(be), .o_readdata(rdata),
    .o_waitrequest(wait_req), .o_status_int(stat_int), .o_irq(irq));
  cei_host_model i_cei_host_model (
    .i_clk_sys(clk), .i_waitrequest(wait_req), .i_readdata(rdata), .o_address(addr), .o_read(rd),
    .o_write(wr), .o_writedata(wdata), .o_byteenable(be));
  // ==========================================================
  // Expectations and checks
  function automatic logic [7:0] live_exp(input cei_pkg::cei_src_t s);
    live_exp = {s.pll_unlock & ~s.input_missing, s.input_missing, s.vco_tuning, 3'b000, s.backup_to_main_switch, 1'b0};
  endfunction
  function automatic logic [7:0] flag_exp(input int k);
    flag_exp = (k == 0) ? 8'h02 : 8'(8'h01 << (k + 4));
  endfunction
  task automatic bus(input logic r, input logic [5:0] idx, input logic [7:0] wd);
    i_cei_host_model.xfer(r, idx, lo, ben, wd, val);
  endtask
  task automatic chk_reg(input string what, input logic [5:0] idx, input logic [7:0] exp);
    bus(1'b1, idx, 8'h00);
    comparisons++;
    if (val !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, val);
    end
    comparisons++;
    if (rdata[31:8] !== 24'h00_0000) begin
      failures++;
      $display("mismatch %s upper bits expected 000000 seen %h", what, rdata[31:8]);
    end
  endtask
  task automatic chk_pin(input string what, input bit sel, input logic exp);
    repeat (3) @(posedge clk);
    #1;
    comparisons++;
    if ((sel ? irq : stat_int) !== exp) begin
      failures++;
      $display("mismatch %s expected %b seen %b", what, exp, sel ? irq : stat_int);
    end
  endtask
  task automatic set_src(input logic [3:0] s);
    @(posedge clk);
    src <= s;
    repeat (6) @(posedge clk);
  endtask
  task automatic close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end
  // ==========================================================
  // Tests
  initial begin
    void'($urandom(23));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    chk_reg("mask", cei_pkg::IDX_MASK, 8'h00);
    chk_reg("polarity", cei_pkg::IDX_POL, 8'h00);
    chk_reg("unmapped", 6'h08, 8'h00);
    ben = 4'hE;
    bus(1'b0, cei_pkg::IDX_MASK, 8'h55);
    ben = 4'h1;
    lo = 2'h2;
    bus(1'b0, cei_pkg::IDX_MASK, 8'h55);
    chk_reg("misaligned", cei_pkg::IDX_MASK, 8'h00);
    lo = 2'h0;
    chk_reg("mask", cei_pkg::IDX_MASK, 8'h00);
    $display("test reset done");
    set_src(4'hC);
    chk_reg("live", cei_pkg::IDX_LIVE, 8'h40);
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      set_src(v[3:0]);
      chk_reg("live", cei_pkg::IDX_LIVE, live_exp(v[3:0]));
      chk_reg("flags", cei_pkg::IDX_FLAG, 8'h00);
      chk_pin("status_int", 0, 1'b0);
    end
    bus(1'b0, cei_pkg::IDX_LIVE, 8'hFF);
    chk_reg("live", cei_pkg::IDX_LIVE, live_exp(v[3:0]));
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      bus(1'b0, cei_pkg::IDX_MASK, v);
      chk_reg("mask", cei_pkg::IDX_MASK, v);
      bus(1'b0, cei_pkg::IDX_POL, ~v);
      chk_reg("polarity", cei_pkg::IDX_POL, ~v);
    end
    $display("test live and registers done");
    bus(1'b0, cei_pkg::IDX_MASK, 8'h00);
    bus(1'b0, cei_pkg::IDX_CTRL, 8'h01);
    for (int k = 0; k < 4; k++) begin
      for (int p = 0; p < 2; p++) begin
        bus(1'b0, cei_pkg::IDX_POL, p ? 8'hFF : 8'h00);
        set_src(p ? 4'h0 : 4'(1 << k));
        bus(1'b0, cei_pkg::IDX_FLAG, 8'h00);
        set_src(p ? 4'(1 << k) : 4'h0);
        chk_reg("flags", cei_pkg::IDX_FLAG, flag_exp(k));
        bus(1'b0, cei_pkg::IDX_FLAG, 8'hFF);
        chk_reg("flags", cei_pkg::IDX_FLAG, flag_exp(k));
      end
    end
    $display("test edges done");
    chk_pin("status_int", 0, 1'b1);
    bus(1'b0, cei_pkg::IDX_FLAG, 8'hFF);
    chk_reg("flags", cei_pkg::IDX_FLAG, 8'h80);
    bus(1'b0, cei_pkg::IDX_MASK, 8'h80);
    chk_pin("status_int", 0, 1'b0);
    bus(1'b0, cei_pkg::IDX_MASK, 8'h00);
    bus(1'b0, cei_pkg::IDX_CTRL, 8'h00);
    chk_pin("status_int", 0, 1'b0);
    bus(1'b0, cei_pkg::IDX_CTRL, 8'h03);
    chk_pin("status_int", 0, 1'b0);
    bus(1'b0, cei_pkg::IDX_MASK, 8'h7F);
    chk_pin("status_int", 0, 1'b1);
    bus(1'b0, cei_pkg::IDX_FLAG, 8'h7F);
    chk_reg("flags", cei_pkg::IDX_FLAG, 8'h00);
    chk_pin("status_int", 0, 1'b0);
    $display("test combine done");
    bus(1'b0, cei_pkg::IDX_IRQ_STAT, 8'hFF);
    bus(1'b0, cei_pkg::IDX_IRQ_EN, 8'h80);
    set_src(4'h0);
    set_src(4'h8);
    chk_reg("irq status", cei_pkg::IDX_IRQ_STAT, 8'h80);
    chk_pin("irq", 1, 1'b1);
    bus(1'b0, cei_pkg::IDX_IRQ_EN, 8'h00);
    chk_pin("irq", 1, 1'b0);
    bus(1'b0, cei_pkg::IDX_IRQ_STAT, 8'h80);
    chk_reg("irq status", cei_pkg::IDX_IRQ_STAT, 8'h00);
    $display("test irq done");
    close_out();
  end
endmodule
